// [rtl/melst_defines.svh]
/*
  Constants of the miscellaneous event latch and status block: register
  offsets, bit positions, field widths and reset values.
  Assumes it is included by bare name from the package and the design files.
*/
`ifndef MELST_DEFINES_SVH
`define MELST_DEFINES_SVH

// Register bus geometry
`define MELST_ADDR_W            4
`define MELST_DATA_W            16

// Register offsets (word index on the plain register port)
`define MELST_ADDR_STATUS       4'h0
`define MELST_ADDR_EDGE_SEL     4'h1

// Pin latch layout: pin k owns latch bit 2k+5 and companion bit 2k+4
`define MELST_NUM_PINS          6
`define MELST_PIN_LATCH_LSB     5
`define MELST_PIN_STATE_LSB     4
`define MELST_PIN_STRIDE        2

// Internal event latch layout: events sit in bits 3..0
`define MELST_NUM_EVENTS        4
`define MELST_EVENT_MSB         3
`define MELST_EVENT_LSB         0
`define MELST_EV_FRAME_UNDER    3
`define MELST_EV_SYNC_LOSS      2
`define MELST_EV_RATE_GEN_ONE   1
`define MELST_EV_RATE_GEN_ZERO  0

// Edge select control: two bits per pin, upper twelve bits used
`define MELST_EDGE_SEL_MASK     16'hfff0
`define MELST_EDGE_SEL_RESET    16'h0000

// Latch bits of the status word; companion bits are read only
`define MELST_LATCH_MASK        16'haaaf

// Reset and idle values
`define MELST_READ_IDLE         16'h0000
`define MELST_STATUS_RESET      16'h0000

`endif

// [rtl/melst_pkg.sv]
/*
  Types of the miscellaneous event latch and status block: the edge select
  code and the packed carriers for pin levels and internal events.
  Assumes the constants header is on the include path.
*/
`include "melst_defines.svh"

package melst_pkg;

  // Which pin transitions arm a latch
  typedef enum logic [1:0] {
    MELST_EDGE_NONE    = 2'h0,
    MELST_EDGE_RISING  = 2'h1,
    MELST_EDGE_FALLING = 2'h2,
    MELST_EDGE_BOTH    = 2'h3
  } melst_edge_sel_t;

  // Watched pin levels, first member is the highest status pair
  typedef struct packed {
    logic rx_clock_pin;
    logic tx_clock_pin;
    logic rx_request_pin;
    logic tx_request_pin;
    logic carrier_pin;
    logic clear_to_send_pin;
  } melst_pins_t;

  // One-cycle event pulses from neighbouring units, first member is bit 3
  typedef struct packed {
    logic frame_count_underflow;
    logic clock_recovery_sync_loss;
    logic rate_gen_one_zero;
    logic rate_gen_zero_zero;
  } melst_events_t;

endpackage : melst_pkg

// [rtl/melst_pin_latch.sv]
/*
  One watched pin: enabled edge detection, a sticky latch and the direction
  of the first enabled edge caught while the latch was open.
  Assumes the pin level is synchronous to clk_i.
*/
`timescale 1ns/1ns

module melst_pin_latch (
  input  wire logic                     clk_i,
  input  wire logic                     rst_n_i,
  input  wire logic                     pin_i,
  input  wire melst_pkg::melst_edge_sel_t edge_sel_i,
  input  wire logic                     reopen_i,
  output logic                          latch_o,
  output logic                          dir_o,
  output logic                          hit_o
);

  logic prev_pin;
  logic primed;
  logic rise;
  logic fall;

  // Previous pin sample; no edge is seen before the first sample
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      prev_pin <= 1'b0;
      primed   <= 1'b0;
    end else begin
      prev_pin <= pin_i;
      primed   <= 1'b1;
    end
  end

  assign rise = primed & pin_i & ~prev_pin;
  assign fall = primed & ~pin_i & prev_pin;

  // Edge select decode
  always_comb begin
    unique case (edge_sel_i)
      melst_pkg::MELST_EDGE_NONE:    hit_o = 1'b0;
      melst_pkg::MELST_EDGE_RISING:  hit_o = rise;
      melst_pkg::MELST_EDGE_FALLING: hit_o = fall;
      melst_pkg::MELST_EDGE_BOTH:    hit_o = rise | fall;
    endcase
  end

  // sticky latch, set wins over reopen
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      latch_o <= 1'b0;
    end else if (hit_o) begin
      latch_o <= 1'b1;
    end else if (reopen_i) begin
      latch_o <= 1'b0;
    end
  end

  // direction of first edge while open
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      dir_o <= 1'b0;
    end else if (hit_o && (!latch_o || reopen_i)) begin
      dir_o <= rise;
    end
  end

endmodule : melst_pin_latch

// [rtl/melst_top.sv]
/*
  Miscellaneous event status register: six pin transition latches with
  direction or inverted live level, four internal event latches, write-one reopen,
  and an edge select control register, all on a plain register port.
  Assumes pins and event pulses are synchronous to clk_i and that the
  register port master never raises both strobes together.
*/
// Design decisions made here: the register addresses and the address-and-strobe port.
`timescale 1ns/1ns
`include "melst_defines.svh"

module melst_top #(
  parameter int ADDR_W = `MELST_ADDR_W,
  parameter int DATA_W = `MELST_DATA_W
) (
  input  wire logic                    clk_i,
  input  wire logic                    rst_n_i,
  input  wire logic [ADDR_W-1:0]       addr_i,
  input  wire logic [DATA_W-1:0]       wr_data_i,
  input  wire logic                    wr_en_i,
  input  wire logic                    rd_en_i,
  input  wire melst_pkg::melst_pins_t  pins_i,
  input  wire melst_pkg::melst_events_t events_i,
  output logic [DATA_W-1:0]            rd_data_o,
  output logic                         event_pending_o
);

  localparam int NP = `MELST_NUM_PINS;
  localparam int NE = `MELST_NUM_EVENTS;

  logic [DATA_W-1:0] edge_sel;
  logic [NP-1:0]     pin_vec;
  logic [NP-1:0]     pin_latch;
  logic [NP-1:0]     pin_dir;
  logic [NP-1:0]     pin_hit;
  logic [NP-1:0]     pin_reopen;
  logic [NE-1:0]     ev_vec;
  logic [NE-1:0]     ev_latch;
  logic [NE-1:0]     ev_clear;
  logic [DATA_W-1:0] status_view;
  logic [DATA_W-1:0] next_rd_data;
  logic              wr_status;
  logic              wr_edge_sel;
  logic              rd_status;
  logic              rd_edge_sel;

  // Address decode of the register port
  assign wr_status   = wr_en_i && (addr_i == `MELST_ADDR_STATUS);
  assign wr_edge_sel = wr_en_i && (addr_i == `MELST_ADDR_EDGE_SEL);
  assign rd_status   = rd_en_i && (addr_i == `MELST_ADDR_STATUS);
  assign rd_edge_sel = rd_en_i && (addr_i == `MELST_ADDR_EDGE_SEL);

  assign pin_vec = pins_i;
  assign ev_vec  = events_i;

  // Edge select control, only the pin fields are writable
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      edge_sel <= `MELST_EDGE_SEL_RESET;
    end else if (wr_edge_sel) begin
      edge_sel <= wr_data_i & `MELST_EDGE_SEL_MASK;
    end
  end

  // One latch per watched pin, pin k maps to bits 2k+5 and 2k+4
  for (genvar k = 0; k < NP; k++) begin : g_pin
    localparam int LB = `MELST_PIN_STRIDE * k + `MELST_PIN_LATCH_LSB;
    localparam int SB = `MELST_PIN_STRIDE * k + `MELST_PIN_STATE_LSB;

    // Edge code of this pin, for the checks below
    melst_pkg::melst_edge_sel_t code;
    assign code = melst_pkg::melst_edge_sel_t'(edge_sel[LB:SB]);

    assign pin_reopen[k] = wr_status && wr_data_i[LB];

    melst_pin_latch u_pin (
      .clk_i      (clk_i),
      .rst_n_i    (rst_n_i),
      .pin_i      (pin_vec[k]),
      .edge_sel_i (melst_pkg::melst_edge_sel_t'(edge_sel[LB:SB])),
      .reopen_i   (pin_reopen[k]),
      .latch_o    (pin_latch[k]),
      .dir_o      (pin_dir[k]),
      .hit_o      (pin_hit[k])
    );

    a_pin_edge_latch: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      pin_hit[k] |=> status_view[LB]
    ) else $error("Enabled pin edge did not set its latch bit");

    a_pin_latch_sticky: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      (pin_latch[k] && !pin_reopen[k]) |=> pin_latch[k]
    ) else $error("Pin latch dropped without a write of one");

    a_pin_reopen: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      (pin_reopen[k] && !pin_hit[k]) |=> !pin_latch[k] && (status_view[SB] == !pin_vec[k])
    ) else $error("Write of one did not reopen pin latch and state");

    a_pin_first_dir: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      (!pin_latch[k] && pin_hit[k]) ##1 (pin_latch[k] && !pin_reopen[k]) [*2]
      |-> status_view[SB] == $past(pin_vec[k], 2)
    ) else $error("Companion bit lost the first edge direction");

    a_pin_live_level: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      (rd_status && !pin_latch[k]) |=> rd_data_o[SB] == !$past(pin_vec[k])
    ) else $error("Open companion bit does not track inverted pin");

    // Reopen against a same cycle edge, and direction once latched
    a_pin_set_wins: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      (pin_reopen[k] && pin_hit[k]) |=> pin_latch[k]
    ) else $error("Reopen write beat an enabled pin edge");

    a_pin_dir_reopen: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      (pin_reopen[k] && pin_hit[k]) |=> status_view[SB] == $past(pin_vec[k])
    ) else $error("Edge during reopen did not record its direction");

    a_pin_dir_hold: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      (pin_latch[k] && !pin_reopen[k]) |=> status_view[SB] == $past(status_view[SB])
    ) else $error("Later edge changed a latched direction");

    // Edge code decides which level changes may set the latch
    a_pin_no_edge: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      (!pin_latch[k] && !pin_hit[k]) |=> !pin_latch[k]
    ) else $error("Pin latch set without an enabled edge");

    a_pin_none_code: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      (code == melst_pkg::MELST_EDGE_NONE) |-> !pin_hit[k]
    ) else $error("Disabled pin reported an edge");

    a_pin_rise_only: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      (code == melst_pkg::MELST_EDGE_RISING && pin_hit[k]) |-> pin_vec[k]
    ) else $error("Rising code reported a falling edge");

    a_pin_fall_only: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      (code == melst_pkg::MELST_EDGE_FALLING && pin_hit[k]) |-> !pin_vec[k]
    ) else $error("Falling code reported a rising edge");

    a_pin_rise_hit: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      ((code == melst_pkg::MELST_EDGE_RISING || code == melst_pkg::MELST_EDGE_BOTH)
        && $past(rst_n_i) && pin_vec[k] && !$past(pin_vec[k])) |-> pin_hit[k]
    ) else $error("Enabled rising edge was missed");

    a_pin_fall_hit: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      ((code == melst_pkg::MELST_EDGE_FALLING || code == melst_pkg::MELST_EDGE_BOTH)
        && $past(rst_n_i) && !pin_vec[k] && $past(pin_vec[k])) |-> pin_hit[k]
    ) else $error("Enabled falling edge was missed");
  end

  // event latches, set wins over clear
  assign ev_clear = {NE{wr_status}} & wr_data_i[`MELST_EVENT_MSB:`MELST_EVENT_LSB];

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ev_latch <= NE'(`MELST_STATUS_RESET);
    end else begin
      ev_latch <= ev_vec | (ev_latch & ~ev_clear);
    end
  end

  // status view, companion shows direction or inverted live pin
  always_comb begin
    status_view = `MELST_STATUS_RESET;
    for (int k = 0; k < NP; k++) begin
      status_view[`MELST_PIN_STRIDE * k + `MELST_PIN_LATCH_LSB] = pin_latch[k];
      status_view[`MELST_PIN_STRIDE * k + `MELST_PIN_STATE_LSB] =
        pin_latch[k] ? pin_dir[k] : ~pin_vec[k];
    end
    status_view[`MELST_EVENT_MSB:`MELST_EVENT_LSB] = ev_latch;
  end

  // Read data mux, zero outside the cycle after a read strobe
  always_comb begin
    next_rd_data = `MELST_READ_IDLE;
    if (rd_status) begin
      next_rd_data = status_view;
    end else if (rd_edge_sel) begin
      next_rd_data = edge_sel;
    end
  end

  // Read data register
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rd_data_o <= `MELST_READ_IDLE;
    end else begin
      rd_data_o <= next_rd_data;
    end
  end

  // Summary of every latch for the surrounding logic
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      event_pending_o <= 1'b0;
    end else begin
      event_pending_o <= (|(pin_latch | pin_hit)) || (|ev_latch) || (|ev_vec);
    end
  end

  a_ev_frame_under: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    events_i.frame_count_underflow |=> status_view[`MELST_EV_FRAME_UNDER]
  ) else $error("Frame count underflow not latched");

  a_ev_sync_loss: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    events_i.clock_recovery_sync_loss |=> status_view[`MELST_EV_SYNC_LOSS]
  ) else $error("Clock recovery sync loss not latched");

  a_ev_rate_one: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    events_i.rate_gen_one_zero |=> status_view[`MELST_EV_RATE_GEN_ONE]
  ) else $error("Second rate generator zero not latched");

  a_ev_rate_zero: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    events_i.rate_gen_zero_zero |=> status_view[`MELST_EV_RATE_GEN_ZERO]
  ) else $error("First rate generator zero not latched");

  a_ev_clear_one: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (wr_status && (ev_latch != '0)) |=> ev_latch == ($past(ev_latch) & ~$past(ev_clear) | $past(ev_vec))
  ) else $error("Event latch write of one misbehaved");

  a_zero_write_keeps: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (wr_status && wr_data_i == '0 && pin_hit == '0 && ev_vec == '0)
    |=> (pin_latch == $past(pin_latch)) && (ev_latch == $past(ev_latch))
  ) else $error("Write of zeros changed latch contents");

  a_read_status: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    rd_status |=> rd_data_o == $past(status_view)
  ) else $error("Status read data wrong or late");

  a_read_idle: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    !rd_en_i |=> rd_data_o == '0
  ) else $error("Read data not zero outside a read");

  a_edge_sel_write: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    wr_edge_sel ##1 rd_edge_sel |=> rd_data_o == ($past(wr_data_i, 2) & `MELST_EDGE_SEL_MASK)
  ) else $error("Edge select write not read back");

  // Event latches: set wins, hold, and clear by written ones only
  a_ev_set_wins: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (ev_vec != '0) |=> (ev_latch & $past(ev_vec)) == $past(ev_vec)
  ) else $error("Event lost against a same cycle clear");

  a_ev_hold: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (!wr_status && ev_vec == '0) |=> ev_latch == $past(ev_latch)
  ) else $error("Event latch changed with no event and no write");

  a_ev_clear_only: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (wr_status && ev_vec == '0)
    |=> ev_latch == ($past(ev_latch) & ~$past(wr_data_i[`MELST_EVENT_MSB:`MELST_EVENT_LSB]))
  ) else $error("Event latch clear did not follow written ones");

  a_read_keeps: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (rd_en_i && !wr_en_i && ev_vec == '0) |=> ev_latch == $past(ev_latch)
  ) else $error("Read changed the event latches");

  // Companion bits are read only, a write of them alone changes nothing
  a_companion_write: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (wr_status && ((wr_data_i & `MELST_LATCH_MASK) == '0) && pin_hit == '0 && ev_vec == '0)
    |=> (pin_latch == $past(pin_latch)) && (ev_latch == $past(ev_latch))
  ) else $error("Write of companion bits changed latch contents");

  // Register port: read paths and the edge select register
  a_read_edge_sel: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    rd_edge_sel |=> rd_data_o == $past(edge_sel)
  ) else $error("Edge select read data wrong or late");

  a_read_unmapped: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (rd_en_i && !rd_status && !rd_edge_sel) |=> rd_data_o == '0
  ) else $error("Unmapped read returned nonzero data");

  a_edge_sel_hold: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    !wr_edge_sel |=> edge_sel == $past(edge_sel)
  ) else $error("Edge select changed without a write");

  a_edge_sel_mask: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    wr_edge_sel |=> (edge_sel & ~`MELST_EDGE_SEL_MASK) == '0
  ) else $error("Unused edge select bits were stored");

  // Pending summary follows every latch and every same cycle hit
  a_pending_set: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (pin_hit != '0 || ev_vec != '0) |=> event_pending_o
  ) else $error("Pending flag missed a new hit");

  a_pending_latch: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (pin_latch != '0 || ev_latch != '0) |=> event_pending_o
  ) else $error("Pending flag low while a latch is set");

  a_pending_clear: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (pin_latch == '0 && ev_latch == '0 && pin_hit == '0 && ev_vec == '0) |=> !event_pending_o
  ) else $error("Pending flag high with nothing latched");

  // First cycle after reset: everything closed and quiet
  a_reset_clean: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    $rose(rst_n_i) |-> (edge_sel == `MELST_EDGE_SEL_RESET) && (ev_latch == '0)
      && (pin_latch == '0) && (rd_data_o == '0)
  ) else $error("State not cleared by reset");

endmodule : melst_top

// [tb/tb_melst_top.sv]
/*
  Self-checking bench for the miscellaneous event status block: register
  tasks, pin toggles under every edge code, event pulses and reopen writes.
  Assumes melst_pkg is compiled first and the register port never stalls.
*/
`timescale 1ns/1ns

module tb_melst_top;
  logic                     clk_i;
  logic                     rst_n_i;
  logic [3:0]               addr_i;
  logic [15:0]              wr_data_i;
  logic                     wr_en_i;
  logic                     rd_en_i;
  melst_pkg::melst_pins_t   pins_i;
  melst_pkg::melst_events_t events_i;
  logic [15:0]              rd_data_o;
  logic                     event_pending_o;
  int                       failures;
  int                       cmp_count;
  logic [5:0]               plat;
  logic [5:0]               pdir;
  logic [3:0]               ev;
  logic [15:0]              esel;
  logic [15:0]              got;
  logic [15:0]              pats [5] = '{16'h0000, 16'h5550, 16'haaa0, 16'hfff0, 16'h1b60};

  melst_top u_dut (
    .clk_i           (clk_i),
    .rst_n_i         (rst_n_i),
    .addr_i          (addr_i),
    .wr_data_i       (wr_data_i),
    .wr_en_i         (wr_en_i),
    .rd_en_i         (rd_en_i),
    .pins_i          (pins_i),
    .events_i        (events_i),
    .rd_data_o       (rd_data_o),
    .event_pending_o (event_pending_o)
  );

  // Free running clock
  always #25 clk_i = ~clk_i;

  // Expected status word from the bench's own latch model
  function automatic logic [15:0] exp_st();
    logic [15:0] e;
    e = {12'h000, ev};
    for (int k = 0; k < 6; k++) begin
      e[2*k+5] = plat[k];
      e[2*k+4] = plat[k] ? pdir[k] : ~pins_i[k];
    end
    return e;
  endfunction : exp_st

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk

  // One write cycle, with an optional event pulse in the same cycle
  task automatic wr(input logic [3:0] a, input logic [15:0] d, input logic [3:0] e);
    @(posedge clk_i);
    wr_en_i   <= 1'b1;
    addr_i    <= a;
    wr_data_i <= d;
    events_i  <= e;
    @(posedge clk_i);
    wr_en_i  <= 1'b0;
    events_i <= 4'h0;
  endtask : wr

  // One read cycle; data is taken in the following cycle, then must drop
  task automatic rd(input logic [3:0] a);
    @(posedge clk_i);
    rd_en_i <= 1'b1;
    addr_i  <= a;
    @(posedge clk_i);
    rd_en_i <= 1'b0;
    #1 got = rd_data_o;
    @(posedge clk_i);
    #1 chk(rd_data_o, 16'h0000);
  endtask : rd

  // Status read against the model, pending flag against the latch set
  task automatic st_chk();
    rd(4'h0);
    chk(got, exp_st());
    chk({15'h0000, event_pending_o}, {15'h0000, |{plat, ev}});
  endtask : st_chk

  // Drive new pin levels and update the model for enabled edges
  task automatic set_pins(input logic [5:0] v);
    logic [5:0] old;
    logic [1:0] cd;
    old = pins_i;
    @(posedge clk_i);
    pins_i <= v;
    for (int k = 0; k < 6; k++) begin
      cd = esel[2*k+4 +: 2];
      if (!plat[k] && old[k] != v[k] && (v[k] ? cd[0] : cd[1])) begin
        plat[k] = 1'b1;
        pdir[k] = v[k];
      end
    end
    @(posedge clk_i);
  endtask : set_pins

  task automatic report_and_stop();
    if (failures == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : report_and_stop

  // Watchdog well beyond the expected run length
  initial begin
    #(50 * 20000);
    failures++;
    report_and_stop();
  end

  // Main sequence
  initial begin
    clk_i     = 1'b0;
    rst_n_i   = 1'b0;
    addr_i    = 4'h0;
    wr_data_i = 16'h0000;
    wr_en_i   = 1'b0;
    rd_en_i   = 1'b0;
    pins_i    = 6'h00;
    events_i  = 4'h0;
    failures  = 0;
    cmp_count = 0;
    plat      = 6'h00;
    pdir      = 6'h00;
    ev        = 4'h0;
    esel      = 16'h0000;
    repeat (4) @(posedge clk_i);
    rst_n_i <= 1'b1;
    st_chk();
    // Edge select readback and unmapped place
    wr(4'h1, 16'hffff, 4'h0);
    wr(4'h2, 16'h0000, 4'h0);
    rd(4'h1);
    chk(got, 16'hfff0);
    rd(4'h2);
    chk(got, 16'h0000);
    // Write then read with no gap between the strobes
    @(posedge clk_i);
    wr_en_i   <= 1'b1;
    addr_i    <= 4'h1;
    wr_data_i <= 16'h9c3f;
    @(posedge clk_i);
    wr_en_i <= 1'b0;
    rd_en_i <= 1'b1;
    @(posedge clk_i);
    rd_en_i <= 1'b0;
    #1 chk(rd_data_o, 16'h9c30);
    // Every edge code, uniform and mixed per pin
    for (int p = 0; p < 5; p++) begin
      esel = pats[p];
      wr(4'h1, esel, 4'h0);
      set_pins(6'h15);
      st_chk();
      set_pins(6'h3f);
      st_chk();
      set_pins(6'h00);
      st_chk();
      wr(4'h0, 16'h5550, 4'h0);
      wr(4'h0, 16'h0000, 4'h0);
      st_chk();
      wr(4'h0, 16'haaa0, 4'h0);
      plat = 6'h00;
      st_chk();
    end
    // Pin edge in the same cycle as its reopen write keeps the latch set
    esel = 16'hfff0;
    wr(4'h1, esel, 4'h0);
    set_pins(6'h01);
    @(posedge clk_i);
    pins_i    <= 6'h00;
    wr_en_i   <= 1'b1;
    addr_i    <= 4'h0;
    wr_data_i <= 16'h0020;
    @(posedge clk_i);
    wr_en_i <= 1'b0;
    pdir[0] = 1'b0;
    st_chk();
    // Event latches set, then reopened one at a time
    wr(4'h2, 16'h0000, 4'hf);
    ev = 4'hf;
    st_chk();
    for (int i = 0; i < 4; i++) begin
      wr(4'h0, 16'h0001 << i, 4'h0);
      ev[i] = 1'b0;
      st_chk();
    end
    // Event in the same cycle as the reopen write keeps the latch set
    wr(4'h2, 16'h0000, 4'hf);
    wr(4'h0, 16'h000f, 4'h5);
    ev = 4'h5;
    st_chk();
    report_and_stop();
  end
endmodule : tb_melst_top
